// ===== rtl/operating_mode_sequencer.sv
/*
  Operating-mode state machine: Standby, Pre-standby, Reset, Limp Home
  and Active, with pin timing and ordered control frames.
  Assumes frames arrive decoded as a one-cycle strobe on clk, and that
  watchdog and functional-error flags come from logic on clk.
*/
// Functional notes
// - After power-up start in Standby; SPI off, low consumption.
// - Standby: chip select low beyond wake-up time enters Reset.
// - Pre-standby: chip select high beyond standby entry time goes Standby.
// - Pre-standby: chip select low beyond pre-sleep time goes Reset.
// - Pre-standby keeps boost off and SPI on.
// - Active: unlock frame then (0,1) frame enters Pre-standby.
// - Unlock is control one bit 1; enable bit 3, sleep bit 2.
// - Limp Home: stand-alone pin low beyond its window enters Pre-standby.
// - Active: supply undervoltage or watchdog failure enters Reset.
// - Active: single (0,0) frame enters Reset without unlock.
// - Active: unlock frame then (1,1) frame enters Reset.
// - Reset loads defaults from one-time settings; SPI off.
// - Reset leaves to Limp Home after 400 ns.
// - Limp Home: boost on defaults, SPI on, writes change nothing.
// - Limp Home: unlock frame then sleep=1, enable=0 enters Pre-standby.
// - Active entry: clear watchdog flag, unlock, then enable=1 sleep=0.
// - Limp Home clears functional error every auto-restart period.
// - Active: boost on, SPI on, follows SPI control contents.
// - Frames carry opcode, 6-bit address, 24 payload bits, MSB first.
`timescale 1ns/1ps
module operating_mode_sequencer #(
  parameter int AUTO_RESTART_CYCLES = mode_seq_pkg::AUTO_RESTART_CYC
) (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             resetn,
  // Pins, asynchronous
  input  wire logic                             chip_select_low,
  input  wire logic                             standalone_pin,
  input  wire logic                             vdd_undervoltage,
  // Flags from on-chip logic
  input  wire logic                             watchdog_fail_flag,
  input  wire logic                             functional_error_flag,
  // Decoded frame strobe
  input  wire logic                             frame_valid,
  input  wire logic [mode_seq_pkg::OPC_W-1:0]   frame_opcode,
  input  wire logic [mode_seq_pkg::ADDR_W-1:0]  frame_addr,
  input  wire logic [mode_seq_pkg::DATA_W-1:0]  frame_data,
  // One-time-programmable defaults
  input  wire logic [mode_seq_pkg::DATA_W-1:0]  otp_cfg_one,
  input  wire logic [mode_seq_pkg::DATA_W-1:0]  otp_cfg_two,
  // Mode and block controls
  output mode_seq_pkg::op_mode_type             mode_r,
  output logic                                  boost_enable_r,
  output logic                                  spi_active_r,
  output logic                                  low_power_r,
  output logic                                  spi_cfg_select_r,
  output logic [mode_seq_pkg::DATA_W-1:0]       cfg_one_r,
  output logic [mode_seq_pkg::DATA_W-1:0]       cfg_two_r,
  // Flag clear pulses
  output logic                                  watchdog_fail_flag_clear_r,
  output logic                                  fe_clear_r
);
  import mode_seq_pkg::*;

  op_mode_type    mode_nxt;
  entry_step_type entry_r;
  logic           armed_r;
  logic [RESET_W-1:0] reset_cnt_r;
  logic [DUR_W-1:0]   restart_cnt_r;

  logic             cs_level;
  logic [DUR_W-1:0] cs_dur;
  logic             sa_level;
  logic [DUR_W-1:0] sa_dur;
  logic             uv_level;

  // Pin timing
  pin_level_timer #(.DUR_W(DUR_W), .RESET_LEVEL(1'b1)) u_cs_timer (
    .clk     (clk),
    .resetn  (resetn),
    .pin     (chip_select_low),
    .level_r (cs_level),
    .dur_r   (cs_dur)
  );

  pin_level_timer #(.DUR_W(DUR_W), .RESET_LEVEL(1'b1)) u_sa_timer (
    .clk     (clk),
    .resetn  (resetn),
    .pin     (standalone_pin),
    .level_r (sa_level),
    .dur_r   (sa_dur)
  );

  pin_level_timer #(.DUR_W(DUR_W), .RESET_LEVEL(1'b0)) u_uv_timer (
    .clk     (clk),
    .resetn  (resetn),
    .pin     (vdd_undervoltage),
    .level_r (uv_level),
    .dur_r   ()
  );

  // Window expiries
  logic wake_hit;
  logic standby_hit;
  logic pre_reset_hit;
  logic sa_hit;

  assign wake_hit      = !cs_level && cs_dur > DUR_W'(WAKEUP_CYC);
  assign standby_hit   = cs_level && cs_dur > DUR_W'(STANDBY_ENTRY_CYC);
  assign pre_reset_hit = !cs_level && cs_dur > DUR_W'(PRE_SLEEP_RESET_CYC);
  assign sa_hit        = !sa_level && sa_dur > DUR_W'(STANDALONE_LOW_CYC);

  // Frame decode; frames are only heard while the SPI is active
  logic frame_ok;
  logic write_frame;
  logic unlock_frame;
  logic mode_frame;
  logic wd_clear_frame;
  logic req_enable;
  logic req_sleep;

  assign frame_ok       = frame_valid && spi_active_r;
  assign write_frame    = frame_ok && frame_opcode == OPC_WRITE;
  assign unlock_frame   = write_frame && frame_addr == ADDR_CONTROL_REG_ONE &&
                          frame_data[UNLOCK_BIT];
  assign mode_frame     = write_frame && frame_addr == ADDR_CONTROL_REG_TWO;
  assign req_enable     = frame_data[ENABLE_BIT];
  assign req_sleep      = frame_data[SLEEP_REQUEST_BIT];
  assign wd_clear_frame = frame_ok && frame_opcode == OPC_READ_CLEAR &&
                          frame_addr == ADDR_STATUS_REG_ONE &&
                          frame_data[WATCHDOG_FAIL_BIT];

  // Unlock arms exactly the next frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      armed_r <= 1'b0;
    end else if (frame_ok) begin
      armed_r <= unlock_frame;
    end else if (!spi_active_r) begin
      armed_r <= 1'b0;
    end
  end

  // Three-frame Active entry sequence
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      entry_r <= ENTRY_IDLE;
    end else if (!spi_active_r) begin
      entry_r <= ENTRY_IDLE;
    end else if (frame_ok) begin
      if (wd_clear_frame) begin
        entry_r <= ENTRY_WD_CLEARED;
      end else if (unlock_frame && entry_r == ENTRY_WD_CLEARED) begin
        entry_r <= ENTRY_UNLOCKED;
      end else begin
        entry_r <= ENTRY_IDLE;
      end
    end
  end

  // Mode selection
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      M_STANDBY: begin
        if (wake_hit) begin
          mode_nxt = M_RESET;
        end
      end
      M_PRE_STANDBY: begin
        if (standby_hit) begin
          mode_nxt = M_STANDBY;
        end else if (pre_reset_hit) begin
          mode_nxt = M_RESET;
        end
      end
      M_RESET: begin
        if (reset_cnt_r == RESET_W'(RESET_DELAY_CYC - 1)) begin
          mode_nxt = M_LIMP_HOME;
        end
      end
      M_LIMP_HOME: begin
        if (mode_frame && armed_r && req_sleep && !req_enable) begin
          mode_nxt = M_PRE_STANDBY;
        end else if (mode_frame && entry_r == ENTRY_UNLOCKED &&
                     req_enable && !req_sleep) begin
          mode_nxt = M_ACTIVE;
        end else if (sa_hit) begin
          mode_nxt = M_PRE_STANDBY;
        end
      end
      M_ACTIVE: begin
        if (uv_level || watchdog_fail_flag) begin
          mode_nxt = M_RESET;
        end else if (mode_frame && !req_enable && !req_sleep) begin
          mode_nxt = M_RESET;
        end else if (mode_frame && armed_r && req_enable && req_sleep) begin
          mode_nxt = M_RESET;
        end else if (mode_frame && armed_r && !req_enable && req_sleep) begin
          mode_nxt = M_PRE_STANDBY;
        end
      end
      default: begin
        mode_nxt = M_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= M_STANDBY;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Reset-mode dwell; restarts on every entry
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reset_cnt_r <= '0;
    end else if (mode_r == M_RESET && mode_nxt == M_RESET) begin
      reset_cnt_r <= reset_cnt_r + 1'b1;
    end else begin
      reset_cnt_r <= '0;
    end
  end

  // Block controls follow the next mode so they line up with mode_r
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boost_enable_r   <= 1'b0;
      spi_active_r     <= 1'b0;
      low_power_r      <= 1'b1;
      spi_cfg_select_r <= 1'b0;
    end else begin
      boost_enable_r   <= mode_nxt == M_LIMP_HOME ||
                          mode_nxt == M_ACTIVE;
      spi_active_r     <= mode_nxt == M_PRE_STANDBY ||
                          mode_nxt == M_LIMP_HOME ||
                          mode_nxt == M_ACTIVE;
      low_power_r      <= mode_nxt == M_STANDBY;
      spi_cfg_select_r <= mode_nxt == M_ACTIVE;
    end
  end

  // Control contents: defaults in Reset, SPI writes only in Active
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_one_r <= CFG_RESET;
      cfg_two_r <= CFG_RESET;
    end else if (mode_r == M_RESET) begin
      cfg_one_r <= otp_cfg_one;
      cfg_two_r <= otp_cfg_two;
    end else if (mode_r == M_ACTIVE && write_frame) begin
      // Limp Home writes never reach here and leave behaviour unchanged
      if (frame_addr == ADDR_CONTROL_REG_ONE) begin
        cfg_one_r <= frame_data;
      end
      if (frame_addr == ADDR_CONTROL_REG_TWO) begin
        cfg_two_r <= frame_data;
      end
    end
  end

  // Watchdog flag clear request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_fail_flag_clear_r <= 1'b0;
    end else begin
      watchdog_fail_flag_clear_r <= wd_clear_frame;
    end
  end

  // Auto-restart period runs only in Limp Home
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      restart_cnt_r <= '0;
    end else if (mode_r != M_LIMP_HOME ||
                 restart_cnt_r == DUR_W'(AUTO_RESTART_CYCLES - 1)) begin
      restart_cnt_r <= '0;
    end else begin
      restart_cnt_r <= restart_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fe_clear_r <= 1'b0;
    end else begin
      fe_clear_r <= mode_r == M_LIMP_HOME && functional_error_flag &&
                    restart_cnt_r == DUR_W'(AUTO_RESTART_CYCLES - 1);
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_reset_entered;
    mode_r == M_RESET && $past(mode_r) != M_RESET;
  endsequence

  sequence s_armed_frame(logic en, logic sl);
    armed_r && mode_frame && req_enable == en && req_sleep == sl;
  endsequence

  AST_STANDBY_QUIET: assert property (
    mode_r == M_STANDBY |-> !spi_active_r && low_power_r && !boost_enable_r)
    else $error("Standby with SPI or boost active");

  AST_WAKE_UP: assert property (
    mode_r == M_STANDBY && wake_hit |=> mode_r == M_RESET)
    else $error("Wake-up window did not enter Reset");

  AST_PRE_TO_STANDBY: assert property (
    mode_r == M_PRE_STANDBY && standby_hit |=> mode_r == M_STANDBY)
    else $error("Chip select high did not enter Standby");

  AST_PRE_TO_RESET: assert property (
    mode_r == M_PRE_STANDBY && pre_reset_hit |=> mode_r == M_RESET)
    else $error("Chip select low did not enter Reset");

  AST_PRE_OUTPUTS: assert property (
    mode_r == M_PRE_STANDBY |-> !boost_enable_r && spi_active_r)
    else $error("Pre-standby outputs wrong");

  AST_ACTIVE_SLEEP: assert property (
    (mode_r == M_ACTIVE && !uv_level && !watchdog_fail_flag) and
    s_armed_frame(1'b0, 1'b1) |=> mode_r == M_PRE_STANDBY)
    else $error("Unlocked sleep request ignored");

  AST_ACTIVE_FAULT: assert property (
    mode_r == M_ACTIVE && (uv_level || watchdog_fail_flag) |=>
    mode_r == M_RESET ##1 !spi_active_r)
    else $error("Active fault did not enter Reset");

  AST_ACTIVE_RESTART: assert property (
    (mode_r == M_ACTIVE) and s_armed_frame(1'b1, 1'b1) |=> mode_r == M_RESET)
    else $error("Unlocked restart ignored");

  AST_RESET_DWELL: assert property (
    s_reset_entered |-> (mode_r == M_RESET)[*8] ##13 mode_r == M_LIMP_HOME)
    else $error("Reset did not last 400 ns");

  AST_DEFAULT_LOAD: assert property (
    mode_r == M_RESET |=> cfg_one_r == $past(otp_cfg_one) &&
    cfg_two_r == $past(otp_cfg_two))
    else $error("Defaults not loaded in Reset");

  AST_LIMP_WRITE_KEEP: assert property (
    mode_r == M_LIMP_HOME && $past(mode_r) == M_LIMP_HOME |->
    $stable(cfg_one_r) && $stable(cfg_two_r) && boost_enable_r)
    else $error("Limp Home write changed settings");

  AST_NO_STALE_UNLOCK: assert property (
    frame_ok && !unlock_frame |=> !armed_r)
    else $error("Unlock survived a later frame");

  AST_FE_CLEAR: assert property (
    fe_clear_r |-> $past(mode_r) == M_LIMP_HOME &&
    $past(functional_error_flag))
    else $error("Functional error cleared outside Limp Home");

endmodule // operating_mode_sequencer

// ===== rtl/mode_seq_pkg.sv
/*
  Shared constants and types for the operating-mode sequencer.
  Assumes a 50 MHz system clock and frames already decoded by an SPI engine.
*/
package mode_seq_pkg;

  // Clock rate
  localparam int CLK_MHZ = 50;

  // Mode timing, in ns as specified, then in clock cycles
  localparam int WAKEUP_NS          = 20000;
  localparam int STANDBY_ENTRY_NS   = 60000;
  localparam int PRE_SLEEP_RESET_NS = 60000;
  localparam int STANDALONE_LOW_NS  = 40000;
  localparam int AUTO_RESTART_NS    = 1000000;
  localparam int RESET_DELAY_NS     = 400;

  // Least times round up
  localparam int WAKEUP_CYC          = (WAKEUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STANDBY_ENTRY_CYC   = (STANDBY_ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam int PRE_SLEEP_RESET_CYC =
    (PRE_SLEEP_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int STANDALONE_LOW_CYC  =
    (STANDALONE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int AUTO_RESTART_CYC    = (AUTO_RESTART_NS * CLK_MHZ) / 1000;
  // Typical delay, rounded down, never below one cycle
  localparam int RESET_DELAY_RAW     = (RESET_DELAY_NS * CLK_MHZ) / 1000;
  localparam int RESET_DELAY_CYC     = (RESET_DELAY_RAW < 1) ? 1 :
                                       RESET_DELAY_RAW;

  // Counter widths
  localparam int DUR_W   = 20;
  localparam int RESET_W = 8;

  // Frame layout: 2-bit opcode, 6-bit address, 24-bit payload
  localparam int OPC_W  = 2;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;

  localparam logic [OPC_W-1:0]  OPC_WRITE      = 2'h0;
  localparam logic [OPC_W-1:0]  OPC_READ       = 2'h1;
  localparam logic [OPC_W-1:0]  OPC_READ_CLEAR = 2'h2;

  localparam logic [ADDR_W-1:0] ADDR_CONTROL_REG_ONE = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_REG_TWO = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_STATUS_REG_ONE  = 6'h11;

  // Field positions
  localparam int UNLOCK_BIT            = 1;
  localparam int SLEEP_REQUEST_BIT     = 2;
  localparam int ENABLE_BIT            = 3;
  localparam int WATCHDOG_FAIL_BIT     = 14;

  // Values after reset
  localparam logic [DATA_W-1:0] CFG_RESET = 24'h000000;

  typedef enum logic [2:0] {
    M_STANDBY,
    M_PRE_STANDBY,
    M_RESET,
    M_LIMP_HOME,
    M_ACTIVE
  } op_mode_type;

  typedef enum logic [1:0] {
    ENTRY_IDLE,
    ENTRY_WD_CLEARED,
    ENTRY_UNLOCKED
  } entry_step_type;

endpackage

// ===== rtl/pin_level_timer.sv
/*
  Three-flop pin synchroniser with a debounced level and a saturating
  count of cycles since that level last changed.
  Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
module pin_level_timer #(
  parameter int         DUR_W       = 20,
  parameter logic       RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Pin
  input  wire logic             pin,
  // Results
  output logic                  level_r,
  output logic [DUR_W-1:0]      dur_r
);

  logic [2:0] sync_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_r <= {3{RESET_LEVEL}};
    end else begin
      sync_r <= {sync_r[1:0], pin};
    end
  end

  // Only the second and third flops are compared; the first may be metastable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_r <= RESET_LEVEL;
      dur_r   <= '0;
    end else if (sync_r[1] == sync_r[2] && sync_r[2] != level_r) begin
      level_r <= sync_r[2];
      dur_r   <= '0;
    end else if (dur_r != '1) begin
      dur_r   <= dur_r + 1'b1;
    end
  end

endmodule // pin_level_timer

// ===== tb/host_model.sv
/*
  Host-side partner of the mode sequencer: drives the chip-select and
  stand-alone pins and hands it decoded frames, one task per sequence.
  Assumes mode_seq_pkg is compiled first and clk is the sequencer clock.
*/
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic                       clk,
  // Pins
  output logic                            chip_select_low,
  output logic                            standalone_pin,
  // Decoded frame
  output logic                            frame_valid,
  output logic [mode_seq_pkg::OPC_W-1:0]  frame_opcode,
  output logic [mode_seq_pkg::ADDR_W-1:0] frame_addr,
  output logic [mode_seq_pkg::DATA_W-1:0] frame_data
);
  import mode_seq_pkg::*;

  initial begin
    chip_select_low = 1'b1;
    standalone_pin  = 1'b1;
    frame_valid     = 1'b0;
    frame_opcode    = OPC_READ;
    frame_addr      = '0;
    frame_data      = '0;
  end

  task automatic pins(input logic cs, input logic sa);
    @(posedge clk);
    chip_select_low <= cs;
    standalone_pin  <= sa;
    #1;
  endtask

  // Fields are inverted once the strobe drops, so the sequencer
  // cannot get away with reading them outside the strobe
  task automatic frame(input logic [OPC_W-1:0]  opc,
                       input logic [ADDR_W-1:0] adr,
                       input logic [DATA_W-1:0] dat);
    @(posedge clk);
    chip_select_low <= 1'b0;
    @(posedge clk);
    frame_valid  <= 1'b1;
    frame_opcode <= opc;
    frame_addr   <= adr;
    frame_data   <= dat;
    @(posedge clk);
    frame_valid     <= 1'b0;
    frame_opcode    <= ~opc;
    frame_addr      <= ~adr;
    frame_data      <= ~dat;
    chip_select_low <= 1'b1;
    repeat (2) @(posedge clk);
    // Return off the edge so callers see settled outputs
    #1;
  endtask

  task automatic unlock();
    logic [DATA_W-1:0] d;
    d = '0;
    d[UNLOCK_BIT] = 1'b1;
    frame(OPC_WRITE, ADDR_CONTROL_REG_ONE, d);
  endtask

  task automatic mode_write(input logic en, input logic sl);
    logic [DATA_W-1:0] d;
    d = '0;
    d[ENABLE_BIT] = en;
    d[SLEEP_REQUEST_BIT] = sl;
    frame(OPC_WRITE, ADDR_CONTROL_REG_TWO, d);
  endtask

  task automatic enter_active();
    logic [DATA_W-1:0] d;
    d = '0;
    d[WATCHDOG_FAIL_BIT] = 1'b1;
    frame(OPC_READ_CLEAR, ADDR_STATUS_REG_ONE, d);
    unlock();
    mode_write(1'b1, 1'b0);
  endtask
endmodule // host_model

// ===== tb/tb_operating_mode_sequencer.sv
/*
  Self-checking bench for the operating-mode sequencer, one task per
  scenario. Assumes the package and host_model are compiled first.
*/
`timescale 1ns/1ps
module tb_operating_mode_sequencer;
  import mode_seq_pkg::*;

  // Short auto-restart period keeps the run brief
  localparam int AR = 40;
  localparam logic [DATA_W-1:0] OTP1 = 24'h5a0c3e;
  localparam logic [DATA_W-1:0] OTP2 = 24'h00a5f0;

  logic              clk, resetn;
  logic              chip_select_low, standalone_pin, vdd_undervoltage;
  logic              watchdog_fail_flag, functional_error_flag;
  logic              frame_valid;
  logic [OPC_W-1:0]  frame_opcode;
  logic [ADDR_W-1:0] frame_addr;
  logic [DATA_W-1:0] frame_data;
  op_mode_type       mode_r;
  logic              boost_enable_r, spi_active_r, low_power_r;
  logic              spi_cfg_select_r, watchdog_fail_flag_clear_r, fe_clear_r;
  logic [DATA_W-1:0] cfg_one_r, cfg_two_r;
  int                mismatches = 0, checks_done = 0;
  int                wd_n = 0, fe_n = 0, run = 0, last_run = 0;

  host_model host_model_i (.clk(clk), .chip_select_low(chip_select_low),
    .standalone_pin(standalone_pin), .frame_valid(frame_valid),
    .frame_opcode(frame_opcode), .frame_addr(frame_addr),
    .frame_data(frame_data));

  operating_mode_sequencer #(.AUTO_RESTART_CYCLES(AR))
    operating_mode_sequencer_i (.clk(clk), .resetn(resetn),
    .chip_select_low(chip_select_low), .standalone_pin(standalone_pin),
    .vdd_undervoltage(vdd_undervoltage),
    .watchdog_fail_flag(watchdog_fail_flag),
    .functional_error_flag(functional_error_flag),
    .frame_valid(frame_valid), .frame_opcode(frame_opcode),
    .frame_addr(frame_addr), .frame_data(frame_data),
    .otp_cfg_one(OTP1), .otp_cfg_two(OTP2), .mode_r(mode_r),
    .boost_enable_r(boost_enable_r), .spi_active_r(spi_active_r),
    .low_power_r(low_power_r), .spi_cfg_select_r(spi_cfg_select_r),
    .cfg_one_r(cfg_one_r), .cfg_two_r(cfg_two_r),
    .watchdog_fail_flag_clear_r(watchdog_fail_flag_clear_r), .fe_clear_r(fe_clear_r));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Pulse counts and the length of the last Reset dwell
  always @(posedge clk) begin
    if (watchdog_fail_flag_clear_r === 1'b1) wd_n++;
    if (fe_clear_r === 1'b1) fe_n++;
    if (mode_r === M_RESET) run++;
    else if (run != 0) begin
      last_run = run;
      run = 0;
    end
  end

  task automatic chk(input string nm, input logic [DATA_W-1:0] e,
                     input logic [DATA_W-1:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_mode(input op_mode_type m, input int lim);
    int n;
    n = 0;
    while (mode_r !== m && n < lim) begin
      cyc(1);
      n++;
    end
    chk("mode_r", m, mode_r);
  endtask

  task automatic expect_reset(input int lim);
    wait_mode(M_RESET, lim);
    chk("spi_active_r", 1'b0, spi_active_r);
    wait_mode(M_LIMP_HOME, 40);
    cyc(1);
    chk("reset_dwell", RESET_DELAY_CYC, last_run);
    chk("boost_enable_r", 1'b1, boost_enable_r);
    chk("spi_cfg_select_r", 1'b0, spi_cfg_select_r);
    chk("spi_active_r", 1'b1, spi_active_r);
    chk("cfg_one_r", OTP1, cfg_one_r);
    chk("cfg_two_r", OTP2, cfg_two_r);
  endtask

  task automatic t_standby();
    int n0;
    chk("mode_r", M_STANDBY, mode_r);
    chk("low_power_r", 1'b1, low_power_r);
    chk("spi_active_r", 1'b0, spi_active_r);
    n0 = wd_n;
    host_model_i.enter_active();
    chk("wd_clear_count", 0, wd_n - n0);
    chk("mode_r", M_STANDBY, mode_r);
    // Two lows each short of the window, split by a brief high
    host_model_i.pins(1'b0, 1'b1);
    cyc(600);
    host_model_i.pins(1'b1, 1'b1);
    cyc(10);
    host_model_i.pins(1'b0, 1'b1);
    cyc(600);
    host_model_i.pins(1'b1, 1'b1);
    cyc(20);
    chk("mode_r", M_STANDBY, mode_r);
  endtask

  task automatic t_wake();
    host_model_i.pins(1'b0, 1'b1);
    cyc(990);
    chk("mode_r", M_STANDBY, mode_r);
    expect_reset(60);
    host_model_i.pins(1'b1, 1'b1);
  endtask

  task automatic t_limp();
    int n0;
    host_model_i.frame(OPC_WRITE, ADDR_CONTROL_REG_TWO, 24'hffffff);
    chk("cfg_two_r", OTP2, cfg_two_r);
    host_model_i.unlock();
    host_model_i.mode_write(1'b1, 1'b0);
    chk("mode_r", M_LIMP_HOME, mode_r);
    host_model_i.unlock();
    host_model_i.frame(OPC_READ, ADDR_STATUS_REG_ONE, 24'h000000);
    host_model_i.mode_write(1'b0, 1'b1);
    chk("mode_r", M_LIMP_HOME, mode_r);
    @(posedge clk) functional_error_flag <= 1'b1;
    cyc(2);
    n0 = fe_n;
    cyc(4 * AR);
    chk("fe_clear_count", 4, fe_n - n0);
    @(posedge clk) functional_error_flag <= 1'b0;
    cyc(3);
    n0 = fe_n;
    cyc(2 * AR);
    chk("fe_clear_idle", 0, fe_n - n0);
  endtask

  task automatic t_active();
    int n0;
    n0 = wd_n;
    host_model_i.enter_active();
    chk("wd_clear_count", 1, wd_n - n0);
    chk("mode_r", M_ACTIVE, mode_r);
    chk("spi_cfg_select_r", 1'b1, spi_cfg_select_r);
    chk("boost_enable_r", 1'b1, boost_enable_r);
    host_model_i.frame(OPC_WRITE, ADDR_CONTROL_REG_ONE, 24'h000400);
    chk("cfg_one_r", 24'h000400, cfg_one_r);
    host_model_i.unlock();
    host_model_i.frame(OPC_READ, ADDR_STATUS_REG_ONE, 24'h000000);
    host_model_i.mode_write(1'b0, 1'b1);
    chk("mode_r", M_ACTIVE, mode_r);
    host_model_i.mode_write(1'b1, 1'b1);
    chk("mode_r", M_ACTIVE, mode_r);
    host_model_i.unlock();
    host_model_i.mode_write(1'b1, 1'b1);
    expect_reset(10);
  endtask

  task automatic t_faults();
    host_model_i.enter_active();
    host_model_i.mode_write(1'b0, 1'b0);
    expect_reset(10);
    host_model_i.enter_active();
    @(posedge clk) vdd_undervoltage <= 1'b1;
    expect_reset(10);
    @(posedge clk) vdd_undervoltage <= 1'b0;
    host_model_i.enter_active();
    @(posedge clk) watchdog_fail_flag <= 1'b1;
    expect_reset(10);
    @(posedge clk) watchdog_fail_flag <= 1'b0;
  endtask

  task automatic t_sleep();
    host_model_i.enter_active();
    host_model_i.unlock();
    host_model_i.mode_write(1'b0, 1'b1);
    wait_mode(M_PRE_STANDBY, 5);
    chk("boost_enable_r", 1'b0, boost_enable_r);
    chk("spi_active_r", 1'b1, spi_active_r);
    cyc(2900);
    chk("mode_r", M_PRE_STANDBY, mode_r);
    wait_mode(M_STANDBY, 200);
    chk("low_power_r", 1'b1, low_power_r);
  endtask

  task automatic t_standalone();
    host_model_i.pins(1'b0, 1'b1);
    expect_reset(1100);
    host_model_i.pins(1'b1, 1'b0);
    cyc(1950);
    chk("mode_r", M_LIMP_HOME, mode_r);
    wait_mode(M_PRE_STANDBY, 100);
    host_model_i.pins(1'b0, 1'b1);
    cyc(2950);
    chk("mode_r", M_PRE_STANDBY, mode_r);
    expect_reset(150);
    host_model_i.pins(1'b1, 1'b1);
    host_model_i.unlock();
    host_model_i.mode_write(1'b0, 1'b1);
    wait_mode(M_PRE_STANDBY, 5);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    resetn                = 1'b0;
    vdd_undervoltage      = 1'b0;
    watchdog_fail_flag    = 1'b0;
    functional_error_flag = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    cyc(2);
    t_standby();
    t_wake();
    t_limp();
    t_active();
    t_faults();
    t_sleep();
    t_standalone();
    conclude();
  end

  // All scenarios take some 12000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule // tb_operating_mode_sequencer
